// ===== irq_steer_pkg.sv
// Shared constants and carrier types for the two-request interrupt steering block
package irq_steer_pkg;

  // Channel map
  localparam int NUM_CH    = 13;
  localparam int NUM_EXT   = 6;
  localparam int NUM_TMR   = 3;
  localparam int NUM_UART  = 3;
  localparam int NUM_ENA   = 12;
  localparam int CH_TMR0   = 6;
  localparam int CH_UART0  = 9;
  localparam int CH_WDOG   = 12;

  // Register byte offsets
  localparam logic [7:0] OFS_EXT_TRIGGER_CONFIG    = 8'h00;
  localparam logic [7:0] OFS_TIMER_POLARITY_CONFIG = 8'h04;
  localparam logic [7:0] OFS_EDGE_CLEAR            = 8'h08;
  localparam logic [7:0] OFS_LOW_PRIO_ENABLE       = 8'h0c;
  localparam logic [7:0] OFS_HIGH_PRIO_ENABLE      = 8'h10;
  localparam logic [7:0] OFS_LOW_PRIO_STATUS       = 8'h14;
  localparam logic [7:0] OFS_HIGH_PRIO_STATUS      = 8'h18;
  localparam logic [7:0] OFS_RAW_PENDING_VIEW      = 8'h1c;

  // Field positions
  localparam int EXT_POL_POS   = 0;   // polarity at 2i
  localparam int EXT_TRIG_POS  = 1;   // trigger type at 2i+1
  localparam int EXT_CFG_W     = 12;
  localparam int TMR_POL_W     = 3;
  localparam int CLR_NORMAL_W  = 9;   // bits 0..8 -> channels 0..8
  localparam int CLR_WDOG_POS  = 9;

  // Reset values
  localparam logic [11:0] EXT_CFG_RST = 12'h000;
  localparam logic [2:0]  TMR_POL_RST = 3'h0;
  localparam logic [11:0] ENA_RST     = 12'h000;

  // Avalon-MM request from the master
  typedef struct packed {
    logic        read;
    logic        write;
    logic [7:0]  address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } avs_req_type;

  // One channel's latch state
  typedef struct packed {
    logic prev;
    logic latch;
  } chan_state_type;

  // Controller state
  typedef struct packed {
    logic [11:0] ext_trigger_config;
    logic [2:0]  timer_polarity_config;
    logic [11:0] low_prio_enable;
    logic [11:0] high_prio_enable;
    logic        waitrequest;
    logic [31:0] readdata;
    logic        low_prio_req_n;
    logic        fast_request_n;
  } ctl_state_type;

endpackage

// ===== chan_latch.sv
// One interrupt channel: polarity, edge detect and pending latch
`timescale 1ns/1ns

module chan_latch (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_sys_rst,
  // Source and configuration
  input  wire logic i_src,
  input  wire logic i_active_high,
  input  wire logic i_edge_mode,
  input  wire logic i_clear,
  // Pending state
  output logic      o_pending
);

  irq_steer_pkg::chan_state_type state;
  irq_steer_pkg::chan_state_type next_state;
  logic                          edge_seen;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_state = state;
    next_state.prev = i_src;
    edge_seen = i_active_high ? (i_src & ~state.prev) : (~i_src & state.prev);
    if (i_clear) begin
      next_state.latch = 1'b0;
    end
    if (edge_seen) begin
      next_state.latch = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign o_pending = i_edge_mode ? state.latch : (i_src == i_active_high);

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  chk_edge_hold: assert property (state.latch && !i_clear |=> state.latch)
    else $error("edge latch dropped without clear");
  chk_edge_set: assert property (edge_seen |=> state.latch)
    else $error("detected edge not latched");
  chk_clear_edge: assert property (i_clear && !edge_seen |=> !state.latch)
    else $error("clear did not empty latch");
  chk_level_live: assert property (!i_edge_mode |-> o_pending == (i_src == i_active_high))
    else $error("level channel not following source");

endmodule // chan_latch

// ===== irq_steer.sv
// Thirteen-channel interrupt steering to low-priority and fast requests
//
// Implementation choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ns

// How it works
// - OR of pending channels enabled for low priority drives the low request.
// - OR of pending channels enabled for fast drives the fast request.
// - Edge channels latch the edge and hold it until software clears it.
// - Low status bit is pending AND low enable; zero when disabled.
// - Fast status bits 0..11 are pending AND fast enable, zero when disabled; bit 12 is watchdog pending, unmasked.
// - Raw view shows every channel's pending state before any mask.
// - Writing one to a clear bit empties that edge latch; zero does nothing.
// - Clear writes leave level channels alone.
// - Clear bits 0..8 map channels 0..8, bit 9 the watchdog.
// - External config holds polarity at 2i and trigger type at 2i+1.
// - Polarity one means high level or rising edge, zero low or falling.
// - Timer polarity register holds channels 6, 7, 8 in bits 0..2.
// - Timer channels are always edge triggered.
// - UART channels are always level triggered and active high.
// - Watchdog channel 12 is edge triggered and always drives the fast request.
// - Both enable registers have one bit per channel 0..11.
// - Low status register is read only, channels 0..11 in bits 0..11.
// - Channels 0..5 external pins, 6..8 timers, 9..11 UARTs, 12 watchdog.
// - Raw view shows latch for edge channels, live input compared with polarity for level ones.
module irq_steer (
  // Clock and reset
  input  wire logic                       i_clk,
  input  wire logic                       i_sys_rst,
  // Avalon-MM slave
  input  wire irq_steer_pkg::avs_req_type i_avs_req,
  output logic [31:0]                     o_avs_readdata,
  output logic                            o_avs_waitrequest,
  // Interrupt sources
  input  wire logic [5:0]                 i_ext_int,
  input  wire logic [2:0]                 i_timer_int,
  input  wire logic [2:0]                 i_uart_int,
  input  wire logic                       i_wdog_int,
  // Requests to the core, active low
  output logic                            o_low_prio_req_n,
  output logic                            o_fast_request_n
);

  irq_steer_pkg::ctl_state_type state;
  irq_steer_pkg::ctl_state_type next_state;

  logic [12:0] src;
  logic [12:0] active_high;
  logic [12:0] edge_mode;
  logic [12:0] clear;
  logic [12:0] pending;
  logic [11:0] low_prio_status;
  logic [12:0] high_prio_status;
  logic        req;
  logic        commit_wr;
  logic [15:0] wr16;
  logic [15:0] wr_mask;
  logic [15:0] rd16;

  ////////////////////////////////////////////////////////////////////////////
  // Channel configuration

  assign src = {i_wdog_int, i_uart_int, i_timer_int, i_ext_int};

  always_comb begin
    active_high = '0;
    edge_mode   = '0;
    for (int i = 0; i < irq_steer_pkg::NUM_EXT; i++) begin
      active_high[i] = state.ext_trigger_config[2 * i + irq_steer_pkg::EXT_POL_POS];
      edge_mode[i]   = state.ext_trigger_config[2 * i + irq_steer_pkg::EXT_TRIG_POS];
    end
    for (int i = 0; i < irq_steer_pkg::NUM_TMR; i++) begin
      active_high[irq_steer_pkg::CH_TMR0 + i] = state.timer_polarity_config[i];
      edge_mode[irq_steer_pkg::CH_TMR0 + i]   = 1'b1;
    end
    for (int i = 0; i < irq_steer_pkg::NUM_UART; i++) begin
      active_high[irq_steer_pkg::CH_UART0 + i] = 1'b1;
      edge_mode[irq_steer_pkg::CH_UART0 + i]   = 1'b0;
    end
    active_high[irq_steer_pkg::CH_WDOG] = 1'b1;
    edge_mode[irq_steer_pkg::CH_WDOG]   = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  assign req       = i_avs_req.read | i_avs_req.write;
  // Writes land only on the edge where waitrequest is seen low
  assign commit_wr = i_avs_req.write & ~state.waitrequest;
  assign wr_mask   = {{8{i_avs_req.byteenable[1]}}, {8{i_avs_req.byteenable[0]}}};
  assign wr16      = i_avs_req.writedata[15:0];

  always_comb begin
    clear = '0;
    if (commit_wr && i_avs_req.address == irq_steer_pkg::OFS_EDGE_CLEAR) begin
      clear[8:0] = wr16[irq_steer_pkg::CLR_NORMAL_W-1:0] & wr_mask[irq_steer_pkg::CLR_NORMAL_W-1:0];
      clear[irq_steer_pkg::CH_WDOG] = wr16[irq_steer_pkg::CLR_WDOG_POS] & wr_mask[irq_steer_pkg::CLR_WDOG_POS];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel latches

  for (genvar g = 0; g < irq_steer_pkg::NUM_CH; g++) begin : g_chan
    chan_latch u_chan (
      .i_clk         (i_clk),
      .i_sys_rst     (i_sys_rst),
      .i_src         (src[g]),
      .i_active_high (active_high[g]),
      .i_edge_mode   (edge_mode[g]),
      .i_clear       (clear[g]),
      .o_pending     (pending[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status views

  assign low_prio_status = pending[11:0] & state.low_prio_enable;
  // fast status masked, watchdog forced in
  assign high_prio_status = {pending[irq_steer_pkg::CH_WDOG], pending[11:0] & state.high_prio_enable};

  // reserved and write-only read as zero
  always_comb begin
    rd16 = '0;
    unique case (i_avs_req.address)
      irq_steer_pkg::OFS_EXT_TRIGGER_CONFIG:    rd16 = {4'h0, state.ext_trigger_config};
      irq_steer_pkg::OFS_TIMER_POLARITY_CONFIG: rd16 = {13'h0000, state.timer_polarity_config};
      irq_steer_pkg::OFS_LOW_PRIO_ENABLE:       rd16 = {4'h0, state.low_prio_enable};
      irq_steer_pkg::OFS_HIGH_PRIO_ENABLE:      rd16 = {4'h0, state.high_prio_enable};
      irq_steer_pkg::OFS_LOW_PRIO_STATUS:       rd16 = {4'h0, low_prio_status};
      irq_steer_pkg::OFS_HIGH_PRIO_STATUS:      rd16 = {3'h0, high_prio_status};
      irq_steer_pkg::OFS_RAW_PENDING_VIEW:      rd16 = {3'h0, pending};
      default:                                  rd16 = '0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State update

  always_comb begin
    next_state = state;
    // One wait cycle, then one ready cycle per request
    next_state.waitrequest = ~(req & state.waitrequest);
    if (i_avs_req.read && state.waitrequest) begin
      next_state.readdata = {16'h0000, rd16};
    end
    if (commit_wr) begin
      unique case (i_avs_req.address)
        irq_steer_pkg::OFS_EXT_TRIGGER_CONFIG: begin
          next_state.ext_trigger_config =
            (state.ext_trigger_config & ~wr_mask[11:0]) | (wr16[11:0] & wr_mask[11:0]);
        end
        irq_steer_pkg::OFS_TIMER_POLARITY_CONFIG: begin
          next_state.timer_polarity_config =
            (state.timer_polarity_config & ~wr_mask[2:0]) | (wr16[2:0] & wr_mask[2:0]);
        end
        irq_steer_pkg::OFS_LOW_PRIO_ENABLE: begin
          next_state.low_prio_enable =
            (state.low_prio_enable & ~wr_mask[11:0]) | (wr16[11:0] & wr_mask[11:0]);
        end
        irq_steer_pkg::OFS_HIGH_PRIO_ENABLE: begin
          next_state.high_prio_enable =
            (state.high_prio_enable & ~wr_mask[11:0]) | (wr16[11:0] & wr_mask[11:0]);
        end
        default: begin
          next_state.readdata = state.readdata;
        end
      endcase
    end
    next_state.low_prio_req_n = ~(|low_prio_status);
    next_state.fast_request_n = ~(|high_prio_status);
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state.ext_trigger_config    <= irq_steer_pkg::EXT_CFG_RST;
      state.timer_polarity_config <= irq_steer_pkg::TMR_POL_RST;
      state.low_prio_enable       <= irq_steer_pkg::ENA_RST;
      state.high_prio_enable      <= irq_steer_pkg::ENA_RST;
      state.waitrequest           <= 1'b1;
      state.readdata              <= 32'h0000_0000;
      state.low_prio_req_n        <= 1'b1;
      state.fast_request_n        <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  assign o_avs_readdata    = state.readdata;
  assign o_avs_waitrequest = state.waitrequest;
  assign o_low_prio_req_n  = state.low_prio_req_n;
  assign o_fast_request_n  = state.fast_request_n;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  sequence s_req_waits;
    req && state.waitrequest;
  endsequence

  sequence s_one_ready;
    !o_avs_waitrequest ##1 o_avs_waitrequest;
  endsequence

  chk_bus_ready_pulse: assert property (s_req_waits |=> s_one_ready)
    else $error("waitrequest did not give one ready cycle");
  chk_low_req_or: assert property (##1 o_low_prio_req_n == !$past(|(pending[11:0] & state.low_prio_enable)))
    else $error("low request not the OR of enabled channels");
  chk_fast_req_or: assert property (##1 o_fast_request_n == !$past(|high_prio_status))
    else $error("fast request not the OR of enabled channels");
  chk_low_status_mask: assert property ((low_prio_status & ~state.low_prio_enable) == 12'h000)
    else $error("low status set for disabled channel");
  chk_fast_status_mask: assert property ((high_prio_status[11:0] & ~state.high_prio_enable) == 12'h000)
    else $error("fast status set for disabled channel");
  chk_wdog_fast_route: assert property (pending[12] |=> !o_fast_request_n)
    else $error("watchdog did not raise fast request");
  chk_timer_edge_hold: assert property ($rose(pending[6]) && clear[6] == 1'b0 ##1 clear[6] == 1'b0 |-> pending[6])
    else $error("timer channel not held as edge");
  chk_uart_level: assert property (pending[11:9] == i_uart_int)
    else $error("uart channel not live active high");
  chk_clear_wdog_bit: assert property (commit_wr && i_avs_req.address == irq_steer_pkg::OFS_EDGE_CLEAR
                                       && i_avs_req.writedata[9] && i_avs_req.byteenable[1]
                                       && !($rose(i_wdog_int)) |=> !pending[12])
    else $error("clear bit 9 did not clear watchdog");
  chk_reserved_zero: assert property (!o_avs_waitrequest |-> o_avs_readdata[31:13] == 19'h00000)
    else $error("reserved read bits not zero");

  ////////////////////////////////////////////////////////////////////////////
  // Register checks

  // Both lanes enabled, so the whole field is written
  logic full_wr;
  assign full_wr = commit_wr && i_avs_req.byteenable[1:0] == 2'h3;

  sequence s_idle_wait;
    !req && state.waitrequest;
  endsequence

  sequence s_read_wait;
    i_avs_req.read && state.waitrequest;
  endsequence

  sequence s_read_raw;
    i_avs_req.read && state.waitrequest && i_avs_req.address == irq_steer_pkg::OFS_RAW_PENDING_VIEW;
  endsequence

  sequence s_read_low;
    i_avs_req.read && state.waitrequest && i_avs_req.address == irq_steer_pkg::OFS_LOW_PRIO_STATUS;
  endsequence

  sequence s_read_clear;
    i_avs_req.read && state.waitrequest && i_avs_req.address == irq_steer_pkg::OFS_EDGE_CLEAR;
  endsequence

  // Bus answers
  chk_idle_no_ready: assert property (s_idle_wait |=> o_avs_waitrequest)
    else $error("waitrequest dropped with no request");
  chk_read_capture: assert property (s_read_wait |=> o_avs_readdata == {16'h0000, $past(rd16)})
    else $error("read data not captured in wait cycle");
  chk_raw_view_read: assert property (s_read_raw |=> o_avs_readdata[12:0] == $past(pending))
    else $error("raw view read wrong");
  chk_low_status_read: assert property (s_read_low |=>
    o_avs_readdata[11:0] == $past(pending[11:0] & state.low_prio_enable))
    else $error("low status read wrong");
  chk_clear_reads_zero: assert property (s_read_clear |=> o_avs_readdata == 32'h0000_0000)
    else $error("clear register read not zero");

  // Register writes
  chk_ext_cfg_write: assert property (full_wr && i_avs_req.address == irq_steer_pkg::OFS_EXT_TRIGGER_CONFIG |=>
    state.ext_trigger_config == $past(i_avs_req.writedata[11:0]))
    else $error("external config write lost");
  chk_tmr_cfg_write: assert property (full_wr && i_avs_req.address == irq_steer_pkg::OFS_TIMER_POLARITY_CONFIG |=>
    state.timer_polarity_config == $past(i_avs_req.writedata[2:0]))
    else $error("timer polarity write lost");
  chk_low_ena_write: assert property (full_wr && i_avs_req.address == irq_steer_pkg::OFS_LOW_PRIO_ENABLE |=>
    state.low_prio_enable == $past(i_avs_req.writedata[11:0]))
    else $error("low enable write lost");
  chk_high_ena_write: assert property (full_wr && i_avs_req.address == irq_steer_pkg::OFS_HIGH_PRIO_ENABLE |=>
    state.high_prio_enable == $past(i_avs_req.writedata[11:0]))
    else $error("fast enable write lost");
  chk_cfg_hold: assert property (!commit_wr |=>
    $stable(state.ext_trigger_config) && $stable(state.timer_polarity_config))
    else $error("config changed without write");
  chk_ena_hold: assert property (!commit_wr |=>
    $stable(state.low_prio_enable) && $stable(state.high_prio_enable))
    else $error("enable changed without write");
  chk_status_wr_ignored: assert property (commit_wr && i_avs_req.address == irq_steer_pkg::OFS_LOW_PRIO_STATUS |=>
    $stable(state.low_prio_enable) && $stable(state.high_prio_enable))
    else $error("status write changed enables");

  // Channel behaviour
  chk_ext_level_ch0: assert property (!state.ext_trigger_config[1] |->
    pending[0] == (i_ext_int[0] == state.ext_trigger_config[0]))
    else $error("channel 0 level sense wrong");
  chk_ext_level_ch5: assert property (!state.ext_trigger_config[11] |->
    pending[5] == (i_ext_int[5] == state.ext_trigger_config[10]))
    else $error("channel 5 level sense wrong");
  chk_ext_rise_ch1: assert property (state.ext_trigger_config[3:2] == 2'h3 && $rose(i_ext_int[1])
    && !commit_wr |=> pending[1])
    else $error("channel 1 rising edge not latched");
  chk_tmr_fall_ch6: assert property (!state.timer_polarity_config[0] && $fell(i_timer_int[0])
    && !commit_wr |=> pending[6])
    else $error("timer 0 falling edge not latched");
  chk_tmr_rise_ch7: assert property (state.timer_polarity_config[1] && $rose(i_timer_int[1])
    && !commit_wr |=> pending[7])
    else $error("timer 1 rising edge not latched");
  chk_wdog_latch: assert property ($rose(i_wdog_int) |=> pending[12])
    else $error("watchdog edge not latched");
  chk_ext_clear_ch1: assert property (commit_wr && i_avs_req.address == irq_steer_pkg::OFS_EDGE_CLEAR
    && i_avs_req.writedata[1] && i_avs_req.byteenable[0] && state.ext_trigger_config[3]
    && !$changed(i_ext_int[1]) |=> !pending[1])
    else $error("clear bit 1 did not empty latch");
  chk_low_req_idle: assert property (!(|low_prio_status) |=> o_low_prio_req_n)
    else $error("low request with no enabled channel");
  chk_fast_req_idle: assert property (!(|high_prio_status) |=> o_fast_request_n)
    else $error("fast request with no enabled channel");

endmodule // irq_steer

// ===== core_req_model.sv
// Behavioural processor core that receives the two active-low request lines
`timescale 1ns/1ns

module core_req_model (
  // Clock
  input  wire logic i_clk,
  // Request lines from the steering block
  input  wire logic i_low_prio_req_n,
  input  wire logic i_fast_request_n,
  // Requests as the core sees them after synchronisation
  output logic      o_irq_seen,
  output logic      o_fiq_seen
);
  logic [1:0] low_sync;
  logic [1:0] fast_sync;

  initial begin
    low_sync  = 2'h0;
    fast_sync = 2'h0;
  end

  // falling edge sampling
  // Two stages, since the lines come from another clock phase
  always @(negedge i_clk) begin
    low_sync  <= {low_sync[0], !i_low_prio_req_n};
    fast_sync <= {fast_sync[0], !i_fast_request_n};
  end

  assign o_irq_seen = low_sync[1];
  assign o_fiq_seen = fast_sync[1];
endmodule // core_req_model

// ===== tb.sv
// Self-checking bench for the interrupt steering block
`timescale 1ns/1ns

module tb;
  logic                       i_clk;
  logic                       i_sys_rst;
  irq_steer_pkg::avs_req_type avs_req;
  logic [31:0]                o_avs_readdata;
  logic                       o_avs_waitrequest;
  logic [5:0]                 ext_int;
  logic [2:0]                 timer_int;
  logic [2:0]                 uart_int;
  logic                       wdog_int;
  logic                       o_low_prio_req_n;
  logic                       o_fast_request_n;
  logic                       irq_seen;
  logic                       fiq_seen;
  int                         miscompares;
  int                         num_checks;

  irq_steer u_irq_steer (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_avs_req(avs_req),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest), .i_ext_int(ext_int),
    .i_timer_int(timer_int), .i_uart_int(uart_int), .i_wdog_int(wdog_int),
    .o_low_prio_req_n(o_low_prio_req_n), .o_fast_request_n(o_fast_request_n));

  core_req_model u_core_req_model (.i_clk(i_clk), .i_low_prio_req_n(o_low_prio_req_n),
    .i_fast_request_n(o_fast_request_n), .o_irq_seen(irq_seen), .o_fiq_seen(fiq_seen));

  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = !i_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // Holds the request until waitrequest is sampled low at a rising edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge i_clk);
    avs_req.read       <= !wr;
    avs_req.write      <= wr;
    avs_req.address    <= a;
    avs_req.writedata  <= {16'h0000, d};
    avs_req.byteenable <= 4'h3;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_avs_waitrequest !== 1'b0 && n < 20);
    if (n >= 20) begin
      miscompares++;
      $display("Error at %0t: bus answer missing", $time);
    end
    q = o_avs_readdata;
    avs_req.read  <= 1'b0;
    avs_req.write <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 16'h0000, q);
    check(q, exp);
  endtask

  // Sources change just after an edge, then enough cycles pass for the core to see it
  task automatic src(input logic [5:0] e, input logic [2:0] t, input logic [2:0] u, input logic w);
    @(posedge i_clk);
    ext_int   <= e;
    timer_int <= t;
    uart_int  <= u;
    wdog_int  <= w;
    repeat (5) @(posedge i_clk);
  endtask

  task automatic reqs(input logic [3:0] exp);
    repeat (5) @(posedge i_clk);
    check({28'h0, o_low_prio_req_n, o_fast_request_n, irq_seen, fiq_seen}, {28'h0, exp});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #300000;
    miscompares++;
    $display("Error at %0t: run hung", $time);
    conclude();
  end

  initial begin
    miscompares = 0;
    num_checks  = 0;
    i_sys_rst   = 1'b1;
    avs_req     = '0;
    // External pins idle high: after reset they are level active low
    ext_int     = 6'h3f;
    timer_int   = 3'h0;
    uart_int    = 3'h0;
    wdog_int    = 1'b0;
    repeat (5) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    for (int a = 0; a <= 32; a += 4) rd(8'(a), 32'h0);
    reqs(4'b1100);
    // Register widths and reserved bits
    wr(8'h00, 16'hffff); rd(8'h00, 32'h0fff);
    wr(8'h04, 16'h00ff); rd(8'h04, 32'h0007);
    wr(8'h0c, 16'hffff); rd(8'h0c, 32'h0fff);
    wr(8'h0c, 16'h0000);
    wr(8'h10, 16'hffff); rd(8'h10, 32'h0fff);
    wr(8'h10, 16'h0000); wr(8'h00, 16'h0000); wr(8'h04, 16'h0000);
    wr(8'h08, 16'hffff); rd(8'h08, 32'h0);
    wr(8'h14, 16'hffff); rd(8'h14, 32'h0);
    rd(8'h1c, 32'h0);
    // Level external channels, both polarities
    wr(8'h00, 16'h0001); rd(8'h1c, 32'h0001);
    src(6'h3e, 3'h0, 3'h0, 1'b0); rd(8'h1c, 32'h0);
    src(6'h3a, 3'h0, 3'h0, 1'b0); rd(8'h1c, 32'h0004);
    // one request per channel at a time
    wr(8'h0c, 16'h0004); rd(8'h14, 32'h0004);
    rd(8'h18, 32'h0);
    reqs(4'b0110);
    wr(8'h0c, 16'h0000); rd(8'h14, 32'h0);
    wr(8'h10, 16'h0004); rd(8'h18, 32'h0004);
    reqs(4'b1001);
    src(6'h3f, 3'h0, 3'h0, 1'b0); reqs(4'b1100);
    wr(8'h10, 16'h0000);
    // Edge external channel 1, rising
    wr(8'h00, 16'h000c);
    wr(8'h08, 16'h0002);
    src(6'h3d, 3'h0, 3'h0, 1'b0); rd(8'h1c, 32'h0);
    src(6'h3f, 3'h0, 3'h0, 1'b0);
    src(6'h3d, 3'h0, 3'h0, 1'b0); rd(8'h1c, 32'h0002);
    wr(8'h0c, 16'h0002); rd(8'h14, 32'h0002);
    reqs(4'b0110);
    wr(8'h08, 16'h0000); rd(8'h1c, 32'h0002);
    wr(8'h08, 16'h0002); rd(8'h1c, 32'h0);
    rd(8'h14, 32'h0);
    reqs(4'b1100);
    wr(8'h0c, 16'h0000); wr(8'h00, 16'h0000);
    // UART level channel ignores clear writes
    src(6'h3f, 3'h0, 3'h2, 1'b0); rd(8'h1c, 32'h0400);
    wr(8'h08, 16'h03ff); rd(8'h1c, 32'h0400);
    src(6'h3f, 3'h0, 3'h0, 1'b0); rd(8'h1c, 32'h0);
    // Timers: falling edge by default, rising when polarity set
    src(6'h3f, 3'h1, 3'h0, 1'b0); rd(8'h1c, 32'h0);
    src(6'h3f, 3'h0, 3'h0, 1'b0); rd(8'h1c, 32'h0040);
    wr(8'h04, 16'h0002);
    src(6'h3f, 3'h2, 3'h0, 1'b0); rd(8'h1c, 32'h00c0);
    wr(8'h08, 16'h01c0); rd(8'h1c, 32'h0);
    wr(8'h04, 16'h0000);
    src(6'h3f, 3'h0, 3'h0, 1'b0);
    wr(8'h08, 16'h01c0);
    // Watchdog reaches the fast request with no enables
    src(6'h3f, 3'h0, 3'h0, 1'b1); rd(8'h1c, 32'h1000);
    rd(8'h18, 32'h1000);
    rd(8'h14, 32'h0);
    reqs(4'b1001);
    wr(8'h08, 16'h0100); rd(8'h1c, 32'h1000);
    wr(8'h08, 16'h0200); rd(8'h1c, 32'h0);
    reqs(4'b1100);
    conclude();
  end
endmodule // tb
